// *** design/timer_capture_params.svh ***
// Constants for the pulse capture and channel chaining control block.
// Assumes an APB master on pclk and a timer counter in the same domain.
// What this block does
// - Once armed, the count at the first rising capture edge goes to the rise register and the count at the next falling edge to the fall register.
// - The arm bit clears itself after a rising then falling edge ends the capture.
// - The arm bit is set only by writing one after it was read as zero.
// - One arming gives one capture of one pulse, and the arm bit sits at bit 4, resets to zero and is read/write.
// - Chain register bits 7, 6 and 3 to 0 always read as one and ignore writes.
// - Chain register bit 5 selects the X channel clock and bit 4 the Y channel clock, both reset to zero.
// - With the arm bit at zero the capture input leaves the capture registers alone, except in the cycle just after a write clears the arm bit.
// - A capture edge arriving during a read of the capture registers is applied one cycle later.
// - Y clock field 3'b100 with the Y select bit set joins Y and X into one 16-bit counter, Y as upper byte.
// - X clock field 3'b100 with the X select bit set makes X count compare-match A of Y.
`ifndef TIMER_CAPTURE_PARAMS_SVH
`define TIMER_CAPTURE_PARAMS_SVH
`define OFS_CAPTURE_CONTROL 8'h00
`define OFS_CHAIN_CLOCK 8'h04
`define OFS_RISE_CAPTURE 8'h08
`define OFS_FALL_CAPTURE 8'h0C
`define OFS_CLOCK_FIELD 8'h10
`define POS_ARM 4
`define POS_SEL_X 5
`define POS_SEL_Y 4
`define MASK_CAP_RSVD 8'hEF
`define CHAIN_FIXED_ONES 8'hCF
`define RST_CAPTURE_CONTROL 8'h00
`define RST_CAPTURE_VALUE 8'h00
`define RST_CLOCK_FIELD 3'h0
`define CLOCK_FIELD_CASCADE 3'h4
`define POS_FIELD_X 0
`define POS_FIELD_Y 4
`endif

// *** design/timer_capture_pkg.sv ***
// Types shared by the capture control block and its bench.
// Assumes the constants header is included where offsets are needed.
package timer_capture_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_WAIT_RISE = 2'b01,
    CAP_WAIT_FALL = 2'b10
  } cap_state_t;
endpackage

// *** design/timer_pulse_capture_ctrl.sv ***
// Pulse width capture and channel chaining control, APB slave.
// Assumes timer_count and y_cmatch_a come from logic on pclk.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "timer_capture_params.svh"
module timer_pulse_capture_ctrl (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire timer_capture_pkg::apb_req_t apb_req, // APB request
  output timer_capture_pkg::apb_rsp_t apb_rsp, // APB response
  input wire logic capture_input, // Capture pin, asynchronous
  input wire logic [7:0] timer_count, // Running X counter
  input wire logic y_cmatch_a, // Y compare-match A pulse
  output logic cascade_16_ff, // Y and X form one 16-bit counter
  output logic x_cmatch_count_ff, // X counts Y compare-match A
  output logic x_count_inc_ff, // X increment pulse from Y match
  output logic capture_done_ff // One-cycle pulse, capture ended
);
  import timer_capture_pkg::*;

  logic [7:0] cap_ctrl_ff;
  logic [7:0] nxt_cap_ctrl;
  logic sel_x_ff;
  logic sel_y_ff;
  logic [2:0] field_x_ff;
  logic [2:0] field_y_ff;
  logic [7:0] rise_cap_ff;
  logic [7:0] fall_cap_ff;
  logic read_zero_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic pend_rise_ff;
  logic pend_fall_ff;
  cap_state_t state_ff;
  cap_state_t nxt_state;
  logic setup;
  logic done;
  logic wr;
  logic rd;
  logic cap_read;
  logic rise_edge;
  logic fall_edge;
  logic rise_go;
  logic fall_go;
  logic arm_clear;
  logic mapped;
  logic [7:0] rd_byte;
  logic [7:0] chain_read;

  assign setup = apb_req.psel && !apb_req.penable;
  assign done = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign wr = done && apb_req.pwrite && mapped;
  assign rd = done && !apb_req.pwrite && mapped;
  assign chain_read = `CHAIN_FIXED_ONES
    | ({7'h00, sel_x_ff} << `POS_SEL_X)
    | ({7'h00, sel_y_ff} << `POS_SEL_Y);

  // Address decode and read mux
  always_comb
  begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    unique case (apb_req.paddr)
      `OFS_CAPTURE_CONTROL:
      begin
        rd_byte = cap_ctrl_ff;
      end
      `OFS_CHAIN_CLOCK:
      begin
        rd_byte = chain_read;
      end
      `OFS_RISE_CAPTURE:
      begin
        rd_byte = rise_cap_ff;
      end
      `OFS_FALL_CAPTURE:
      begin
        rd_byte = fall_cap_ff;
      end
      `OFS_CLOCK_FIELD:
      begin
        rd_byte = {1'b0, field_y_ff, 1'b0, field_x_ff};
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  // Capture registers busy with a read
  assign cap_read = apb_req.psel && !apb_req.pwrite
    && ((apb_req.paddr == `OFS_RISE_CAPTURE) || (apb_req.paddr == `OFS_FALL_CAPTURE));

  // APB response, one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_rsp <= '0;
    end
    else if (setup)
    begin
      apb_rsp.pready <= 1'b1;
      apb_rsp.pslverr <= !mapped;
      apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end
    else if (done)
    begin
      apb_rsp <= '0;
    end
  end

  // Synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= capture_input;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign rise_edge = sync2_ff && !prev_ff;
  assign fall_edge = !sync2_ff && prev_ff;

  // Edges that meet a capture read wait one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_rise_ff <= 1'b0;
      pend_fall_ff <= 1'b0;
    end
    else
    begin
      pend_rise_ff <= rise_edge && cap_read && (state_ff == CAP_WAIT_RISE);
      pend_fall_ff <= fall_edge && cap_read && (state_ff == CAP_WAIT_FALL);
    end
  end

  assign rise_go = (state_ff == CAP_WAIT_RISE)
    && ((rise_edge && !cap_read) || pend_rise_ff);
  assign fall_go = (state_ff == CAP_WAIT_FALL)
    && ((fall_edge && !cap_read) || pend_fall_ff);

  // Capture sequence
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      CAP_IDLE:
      begin
        if (cap_ctrl_ff[`POS_ARM])
        begin
          nxt_state = CAP_WAIT_RISE;
        end
      end
      CAP_WAIT_RISE:
      begin
        if (rise_go)
        begin
          nxt_state = CAP_WAIT_FALL;
        end
      end
      CAP_WAIT_FALL:
      begin
        if (fall_go)
        begin
          nxt_state = CAP_IDLE;
        end
      end
      default:
      begin
        nxt_state = CAP_IDLE;
      end
    endcase
    if (!cap_ctrl_ff[`POS_ARM])
    begin
      nxt_state = CAP_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= CAP_IDLE;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign arm_clear = fall_go;

  // Capture value registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rise_cap_ff <= `RST_CAPTURE_VALUE;
      fall_cap_ff <= `RST_CAPTURE_VALUE;
    end
    else
    begin
      if (rise_go)
      begin
        rise_cap_ff <= timer_count;
      end
      if (fall_go)
      begin
        fall_cap_ff <= timer_count;
      end
    end
  end

  // Arm bit may be set only after it was read as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_zero_ff <= 1'b0;
    end
    else if (wr && (apb_req.paddr == `OFS_CAPTURE_CONTROL))
    begin
      read_zero_ff <= 1'b0;
    end
    else if (rd && (apb_req.paddr == `OFS_CAPTURE_CONTROL))
    begin
      read_zero_ff <= !apb_rsp.prdata[`POS_ARM];
    end
  end

  always_comb
  begin
    nxt_cap_ctrl = cap_ctrl_ff;
    if (arm_clear)
    begin
      nxt_cap_ctrl[`POS_ARM] = 1'b0;
    end
    if (wr && (apb_req.paddr == `OFS_CAPTURE_CONTROL))
    begin
      nxt_cap_ctrl = (nxt_cap_ctrl & ~`MASK_CAP_RSVD)
        | (apb_req.pwdata[7:0] & `MASK_CAP_RSVD);
      if (!apb_req.pwdata[`POS_ARM])
      begin
        nxt_cap_ctrl[`POS_ARM] = 1'b0;
      end
      else if (read_zero_ff && !cap_ctrl_ff[`POS_ARM])
      begin
        nxt_cap_ctrl[`POS_ARM] = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_ctrl_ff <= `RST_CAPTURE_CONTROL;
    end
    else
    begin
      cap_ctrl_ff <= nxt_cap_ctrl;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      capture_done_ff <= 1'b0;
    end
    else
    begin
      capture_done_ff <= arm_clear;
    end
  end

  // Chain select bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_x_ff <= 1'b0;
      sel_y_ff <= 1'b0;
    end
    else if (wr && (apb_req.paddr == `OFS_CHAIN_CLOCK))
    begin
      sel_x_ff <= apb_req.pwdata[`POS_SEL_X];
      sel_y_ff <= apb_req.pwdata[`POS_SEL_Y];
    end
  end

  // Channel clock fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      field_x_ff <= `RST_CLOCK_FIELD;
      field_y_ff <= `RST_CLOCK_FIELD;
    end
    else if (wr && (apb_req.paddr == `OFS_CLOCK_FIELD))
    begin
      field_x_ff <= apb_req.pwdata[`POS_FIELD_X +: 3];
      field_y_ff <= apb_req.pwdata[`POS_FIELD_Y +: 3];
    end
  end

  // Cascade modes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cascade_16_ff <= 1'b0;
      x_cmatch_count_ff <= 1'b0;
      x_count_inc_ff <= 1'b0;
    end
    else
    begin
      cascade_16_ff <= (field_y_ff == `CLOCK_FIELD_CASCADE) && sel_y_ff;
      x_cmatch_count_ff <= (field_x_ff == `CLOCK_FIELD_CASCADE) && sel_x_ff;
      x_count_inc_ff <= (field_x_ff == `CLOCK_FIELD_CASCADE) && sel_x_ff
        && y_cmatch_a;
    end
  end
endmodule

// *** dv/pulse_source.sv ***
// Pulse source model on the capture pin.
// Assumes pclk from the bench; edges land off the clock edge.
`timescale 1ns/1ps
module pulse_source (
  input wire logic pclk, // Clock
  input wire logic fire, // Start a pulse
  input wire logic [7:0] hi_len, // High cycles
  output logic pin // Capture pin
);
  initial pin = 1'b0;
  always @(posedge pclk)
  begin
    if (fire)
    begin
      #3 pin = 1'b1;
      repeat (hi_len) @(posedge pclk);
      #3 pin = 1'b0;
    end
  end
endmodule

// *** dv/timer_pulse_capture_ctrl_assertions.sv ***
// Port checker for the capture control block.
// Assumes a bind to timer_pulse_capture_ctrl.
`timescale 1ns/1ps
`include "timer_capture_params.svh"
module capture_ctrl_checker (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire timer_capture_pkg::apb_req_t apb_req, // Request
  input wire timer_capture_pkg::apb_rsp_t apb_rsp, // Response
  input wire logic capture_input, // Pin
  input wire logic y_cmatch_a, // Y match
  input wire logic cascade_16_ff, // 16-bit mode
  input wire logic x_cmatch_count_ff, // Match count mode
  input wire logic x_count_inc_ff, // X increment
  input wire logic capture_done_ff // Capture end
);
  import timer_capture_pkg::*;
  logic fin;
  logic wfin;
  assign fin = apb_req.psel && apb_req.penable && apb_rsp.pready;
  assign wfin = fin && apb_req.pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_after_setup_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("pready late");
  chain_ones_a: assert property (fin && !apb_req.pwrite && apb_req.paddr == `OFS_CHAIN_CLOCK
    |-> (apb_rsp.prdata[7:0] & `CHAIN_FIXED_ONES) == `CHAIN_FIXED_ONES) else $error("chain ones");
  cascade_cause_a: assert property ($changed(cascade_16_ff)
    |-> $past(wfin, 2)) else $error("cascade moved");
  xmode_cause_a: assert property ($changed(x_cmatch_count_ff)
    |-> $past(wfin, 2)) else $error("x mode moved");
  inc_follow_a: assert property (y_cmatch_a |=> x_count_inc_ff == x_cmatch_count_ff)
    else $error("inc missing");
  inc_quiet_a: assert property (!y_cmatch_a |=> !x_count_inc_ff)
    else $error("inc spurious");
  done_once_a: assert property (capture_done_ff |=> !capture_done_ff)
    else $error("done held");
  done_pin_a: assert property (capture_done_ff |-> $past(capture_input, 3) == 1'b0)
    else $error("done without fall");
  cover property (capture_done_ff);
  cover property (cascade_16_ff);
  cover property (x_count_inc_ff);
endmodule
bind timer_pulse_capture_ctrl capture_ctrl_checker chk (.pclk, .presetn, .apb_req, .apb_rsp,
  .capture_input, .y_cmatch_a, .cascade_16_ff, .x_cmatch_count_ff, .x_count_inc_ff,
  .capture_done_ff);

// *** dv/test_timer_pulse_capture_ctrl.sv ***
// Directed bench for the capture control block over APB.
// Assumes the design, its checker and the pulse source model.
`timescale 1ns/1ps
`include "timer_capture_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, (a), (e)); end end
module test_timer_pulse_capture_ctrl;
  import timer_capture_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [7:0] tcount = 8'h00;
  logic ymatch = 1'b0;
  logic fire = 1'b0;
  logic cap_pin, casc, xmode, xinc, done, err, got, ec, ex;
  logic [31:0] q;
  int errors = 0;
  int n_tests = 0;
  int tnum = 0;
  logic [7:0] vals [4] = '{8'h00, 8'hFF, 8'h20, 8'h10};
  logic [7:0] fld [3] = '{8'h44, 8'h34, 8'h43};
  logic [7:0] sel [3] = '{8'h30, 8'h30, 8'h10};
  timer_pulse_capture_ctrl dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .capture_input(cap_pin), .timer_count(tcount), .y_cmatch_a(ymatch), .cascade_16_ff(casc),
    .x_cmatch_count_ff(xmode), .x_count_inc_ff(xinc), .capture_done_ff(done));
  pulse_source src (.pclk(pclk), .fire(fire), .hi_len(8'h0A), .pin(cap_pin));
  initial forever #4 pclk = ~pclk;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (rsp.pready !== 1'b1 && k < 20);
    if (rsp.pready !== 1'b1)
    begin
      errors++;
      $display("Error %0t: no pready", $time);
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(q, {24'h0, e})
  endtask
  task automatic pulse(input logic [7:0] v1, input logic [7:0] v2);
    int k = 0;
    got = 1'b0;
    tcount <= v1;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (6) @(posedge pclk);
    tcount <= v2;
    while (got !== 1'b1 && k < 30)
    begin
      @(posedge pclk);
      got = done;
      k++;
    end
    repeat (4) @(posedge pclk);
  endtask
  task tdone;
    tnum++;
    $display("test %0d done", tnum);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    end_sim;
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_rd(`OFS_CAPTURE_CONTROL, `RST_CAPTURE_CONTROL);
    chk_rd(`OFS_CHAIN_CLOCK, `CHAIN_FIXED_ONES);
    chk_rd(`OFS_RISE_CAPTURE, `RST_CAPTURE_VALUE);
    chk_rd(`OFS_FALL_CAPTURE, `RST_CAPTURE_VALUE);
    chk_rd(8'h20, 8'h00);
    `CHK(err, 1'b1)
    tdone();
    foreach (vals[i])
    begin
      xfer(1'b1, `OFS_CHAIN_CLOCK, {24'h0, vals[i]});
      chk_rd(`OFS_CHAIN_CLOCK, `CHAIN_FIXED_ONES | (vals[i] & 8'h30));
    end
    tdone();
    foreach (fld[i])
    begin
      ec = fld[i][6:4] == `CLOCK_FIELD_CASCADE && sel[i][`POS_SEL_Y];
      ex = fld[i][2:0] == `CLOCK_FIELD_CASCADE && sel[i][`POS_SEL_X];
      xfer(1'b1, `OFS_CLOCK_FIELD, {24'h0, fld[i]});
      xfer(1'b1, `OFS_CHAIN_CLOCK, {24'h0, sel[i]});
      ymatch <= 1'b1;
      @(posedge pclk);
      ymatch <= 1'b0;
      @(posedge pclk);
      `CHK(casc, ec)
      `CHK(xmode, ex)
      `CHK(xinc, ex)
    end
    tdone();
    pulse(8'h11, 8'h22);
    `CHK(got, 1'b0)
    chk_rd(`OFS_RISE_CAPTURE, `RST_CAPTURE_VALUE);
    xfer(1'b1, `OFS_CAPTURE_CONTROL, 32'h0);
    xfer(1'b1, `OFS_CAPTURE_CONTROL, 32'h10);
    chk_rd(`OFS_CAPTURE_CONTROL, 8'h00);
    xfer(1'b1, `OFS_CAPTURE_CONTROL, 32'h10);
    chk_rd(`OFS_CAPTURE_CONTROL, 8'h10);
    pulse(8'h5A, 8'hA5);
    `CHK(got, 1'b1)
    chk_rd(`OFS_CAPTURE_CONTROL, 8'h00);
    chk_rd(`OFS_RISE_CAPTURE, 8'h5A);
    chk_rd(`OFS_FALL_CAPTURE, 8'hA5);
    pulse(8'h33, 8'h44);
    `CHK(got, 1'b0)
    chk_rd(`OFS_RISE_CAPTURE, 8'h5A);
    tdone();
    // Rise edge lands on a capture read, count steps one cycle later
    chk_rd(`OFS_CAPTURE_CONTROL, 8'h00);
    xfer(1'b1, `OFS_CAPTURE_CONTROL, 32'h10);
    fire <= 1'b1;
    tcount <= 8'h60;
    fork
      begin
        repeat (3) @(posedge pclk);
        xfer(1'b0, `OFS_RISE_CAPTURE, 32'h0);
      end
      begin
        @(posedge pclk);
        fire <= 1'b0;
        repeat (3) @(posedge pclk);
        tcount <= 8'h61;
      end
    join
    `CHK(q, {24'h0, 8'h5A})
    repeat (16) @(posedge pclk);
    chk_rd(`OFS_RISE_CAPTURE, 8'h61);
    chk_rd(`OFS_FALL_CAPTURE, 8'h61);
    chk_rd(`OFS_CAPTURE_CONTROL, 8'h00);
    tdone();
    end_sim;
  end
endmodule
